// *** logic/rai_pkg.sv ***
// package: constants shared by the reset and interrupt controller
package rai_pkg;
  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [15:0] WATCHDOG_CLEAR_OFS = 16'h1ff0;
  localparam logic [15:0] CONTROL_OFS        = 16'h1fe0;
  localparam logic [15:0] STATUS_OFS         = 16'h1fe4;
  localparam logic [7:0]  UNUSED_VEC_LO      = 8'h00;  // arbitrary stored vector byte
  localparam logic [5:0]  CONTROL_RST        = 6'h00;
  // control fields
  localparam int CTL_WDOG_EN   = 0;
  localparam int CTL_LEVEL     = 1;
  localparam int CTL_PORTA_EN  = 2;
  localparam int CTL_TIMER_LSB = 3;
  // ---------------------------------------------------------------------------
  // vectors
  // ---------------------------------------------------------------------------
  localparam logic [15:0] VEC_RESET = 16'h1ffe;
  localparam logic [15:0] VEC_TRAP  = 16'h1ffc;
  localparam logic [15:0] VEC_IRQ   = 16'h1ffa;
  localparam logic [15:0] VEC_TIMER = 16'h1ff8;
  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam logic [11:0] POR_DELAY_CYC   = 12'hfe0;  // 4064 cycles
  localparam logic [3:0]  IRQ_CLEAR_CYC   = 4'h9;
  localparam logic [2:0]  WDOG_PULSE_CYC  = 3'h4;
  localparam logic [17:0] WDOG_LIMIT_DEF  = 18'h3ffff; // 18 stages
  // ---------------------------------------------------------------------------
  // pin synchroniser layout
  // ---------------------------------------------------------------------------
  localparam int          SYNC_W    = 12;
  localparam int          SY_RESET  = 0;
  localparam int          SY_IRQ    = 1;
  localparam int          SY_VPP    = 2;
  localparam int          SY_CAPT   = 3;
  localparam int          SY_PORTA  = 4;
  localparam logic [11:0] SYNC_INIT = 12'hff2;
  // ---------------------------------------------------------------------------
  // states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_CLEAR = 2'b01
  } rai_irq_state_t;
endpackage : rai_pkg

// *** logic/rai_top.sv ***
// design: reset merge, watchdog and interrupt arbitration with apb registers
`timescale 1ns/1ns
// What this block does
// - internal reset is the registered or of every reset source
// - external reset pin low holds reset until it returns high
// - power-on reset lasts 4064 clock cycles after the clock starts
// - after power-on delay, reset stays while any other source remains
// - enabled 18-stage watchdog counter asserts reset on overflow
// - reading watchdog clear gives unused vector low byte; writing clears counter
// - programming voltage on interrupt pin suppresses watchdog output
// - reset stays asserted after watchdog pulse while another source is active
// - hardware requests stay pending until the current instruction completes
// - at a boundary take request only when mask clear and enabled
// - taking an interrupt stacks state, sets mask, supplies vector
// - several pending requests: reset, then external, then timers, then trap
// - vectors: reset 1ffe, trap 1ffc, external 1ffa, timers 1ff8
// - trap ignores mask; pending hardware requests go before its fetch
// - return from trap restores state, including the mask bit
// - any reset sets mask and points execution at the reset vector
// - falling edge sets latch; latch or low level raises request
// - with level sense off only the edge latch counts
// - enabled port A inputs act exactly like the interrupt pin
// - edge latch clears nine cycles after the interrupt is taken
// - with level sense on, pin still low at return from trap gives another interrupt
// - timer flags are gated by their enables and the mask bit
// - capture pin latched at each external reset release, used after watchdog
module rai_top #(
  parameter logic [17:0] WDOG_LIMIT = rai_pkg::WDOG_LIMIT_DEF
) (
  input  wire logic        MCLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [15:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        RESET_N_IN,
  input  wire logic        IRQ_N_IN,
  input  wire logic        VPP_HIGH_IN,
  input  wire logic        CAPTURE_MODE_PIN_IN,
  input  wire logic [7:0]  PORTA_N_IN,
  input  wire logic [2:0]  TIMER_FLAGS_IN,
  input  wire logic        BOUNDARY_IN,
  input  wire logic        SOFTWARE_TRAP_IN,
  input  wire logic        RETURN_TRAP_IN,
  input  wire logic        STACKED_MASK_IN,
  input  wire logic        MASK_LOAD_IN,
  input  wire logic        MASK_VAL_IN,
  output logic             RST_OUT,
  output logic             TAKE_OUT,
  output logic             STACK_OUT,
  output logic      [15:0] VECTOR_OUT,
  output logic             MASK_OUT,
  output logic             MODE_SEL_OUT
);
  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic [rai_pkg::SYNC_W-1:0] pins;
  logic [rai_pkg::SYNC_W-1:0] s1_q;
  logic [rai_pkg::SYNC_W-1:0] s2_q;
  logic [rai_pkg::SYNC_W-1:0] s3_q;
  logic [rai_pkg::SYNC_W-1:0] stb_q;

  assign pins = {PORTA_N_IN, CAPTURE_MODE_PIN_IN, VPP_HIGH_IN, IRQ_N_IN, RESET_N_IN};

  // a change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < rai_pkg::SYNC_W; gi++) begin : g_sync
      always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
          s1_q[gi]  <= rai_pkg::SYNC_INIT[gi];
          s2_q[gi]  <= rai_pkg::SYNC_INIT[gi];
          s3_q[gi]  <= rai_pkg::SYNC_INIT[gi];
          stb_q[gi] <= rai_pkg::SYNC_INIT[gi];
        end else begin
          s1_q[gi] <= pins[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            stb_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  logic ext_rst_n;
  logic vpp_high;
  assign ext_rst_n = stb_q[rai_pkg::SY_RESET];
  assign vpp_high  = stb_q[rai_pkg::SY_VPP];

  // ---------------------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------------------
  logic [5:0] ctl_q;
  logic       wr_en;
  logic       acc_en;
  assign acc_en = PSEL_IN & PENABLE_IN & PREADY_OUT;
  assign wr_en  = acc_en & PWRITE_IN;

  // option bits survive internal resets so a watchdog reset keeps the watchdog on
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ctl_q <= rai_pkg::CONTROL_RST;
    end else if (wr_en && PADDR_IN == rai_pkg::CONTROL_OFS) begin
      ctl_q <= PWDATA_IN[5:0];
    end
  end

  // ---------------------------------------------------------------------------
  // power-on delay
  // ---------------------------------------------------------------------------
  logic [11:0] por_cnt_q;
  logic        por_q;
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      por_cnt_q <= 12'h000;
      por_q     <= 1'b1;
    end else if (por_q) begin
      por_cnt_q <= por_cnt_q + 12'h001;
      if (por_cnt_q == rai_pkg::POR_DELAY_CYC - 12'h001) begin
        por_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------------------
  logic [17:0] wd_cnt_q;
  logic [2:0]  wd_pulse_q;
  logic        wd_active;
  logic        wd_clear;
  logic        wd_fired_q;
  logic        rst_q;
  assign wd_active = ctl_q[rai_pkg::CTL_WDOG_EN] & ~vpp_high;
  assign wd_clear  = wr_en && PADDR_IN == rai_pkg::WATCHDOG_CLEAR_OFS;

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      wd_cnt_q <= 18'h00000;
    end else if (wd_clear || !wd_active || rst_q) begin
      wd_cnt_q <= 18'h00000;
    end else begin
      wd_cnt_q <= wd_cnt_q + 18'h00001;
    end
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      wd_pulse_q <= 3'h0;
    end else if (wd_active && !rst_q && wd_cnt_q == WDOG_LIMIT) begin
      wd_pulse_q <= rai_pkg::WDOG_PULSE_CYC;
    end else if (wd_pulse_q != 3'h0) begin
      wd_pulse_q <= wd_pulse_q - 3'h1;
    end
  end

  // cause of the latest reset, used for mode selection
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      wd_fired_q <= 1'b0;
    end else if (wd_pulse_q != 3'h0) begin
      wd_fired_q <= 1'b1;
    end else if (!ext_rst_n) begin
      wd_fired_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // reset merge
  // ---------------------------------------------------------------------------
  logic rst_d;
  assign rst_d = por_q | ~ext_rst_n | (wd_pulse_q != 3'h0);

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rst_q <= 1'b1;
    end else begin
      rst_q <= rst_d;
    end
  end

  // ---------------------------------------------------------------------------
  // mode latch
  // ---------------------------------------------------------------------------
  logic ext_rst_n_q;
  logic capt_latch_q;
  logic mode_q;
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ext_rst_n_q  <= 1'b0;
      capt_latch_q <= 1'b0;
      mode_q       <= 1'b0;
    end else begin
      ext_rst_n_q <= ext_rst_n;
      if (ext_rst_n && !ext_rst_n_q) begin
        capt_latch_q <= stb_q[rai_pkg::SY_CAPT];
      end
      // watchdog reset ignores the live pin
      if (rst_q && !rst_d) begin
        mode_q <= wd_fired_q ? capt_latch_q : stb_q[rai_pkg::SY_CAPT];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // external request
  // ---------------------------------------------------------------------------
  logic                    eff_n;
  logic                    eff_n_q;
  logic                    edge_q;
  logic                    irq_req_q;
  logic                    edge_clear;
  rai_pkg::rai_irq_state_t irq_st_q;
  logic [3:0]              clr_cnt_q;
  logic                    take_irq;

  assign eff_n = stb_q[rai_pkg::SY_IRQ] &
                 (~ctl_q[rai_pkg::CTL_PORTA_EN] | (&stb_q[rai_pkg::SYNC_W-1:rai_pkg::SY_PORTA]));
  assign edge_clear = (irq_st_q == rai_pkg::ST_CLEAR) && clr_cnt_q == rai_pkg::IRQ_CLEAR_CYC - 4'h1;

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      eff_n_q <= 1'b1;
      edge_q  <= 1'b0;
    end else begin
      eff_n_q <= eff_n;
      // a new edge in the clearing cycle survives
      if (eff_n_q && !eff_n) begin
        edge_q <= 1'b1;
      end else if (edge_clear || rst_q) begin
        edge_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      irq_req_q <= 1'b0;
    end else begin
      irq_req_q <= edge_q | (ctl_q[rai_pkg::CTL_LEVEL] & ~eff_n);
    end
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      irq_st_q  <= rai_pkg::ST_RUN;
      clr_cnt_q <= 4'h0;
    end else begin
      unique case (irq_st_q)
        rai_pkg::ST_RUN: begin
          clr_cnt_q <= 4'h0;
          if (take_irq) begin
            irq_st_q <= rai_pkg::ST_CLEAR;
          end
        end
        rai_pkg::ST_CLEAR: begin
          clr_cnt_q <= clr_cnt_q + 4'h1;
          if (edge_clear || rst_q) begin
            irq_st_q <= rai_pkg::ST_RUN;
          end
        end
        default: begin
          irq_st_q <= rai_pkg::ST_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------------------
  logic [2:0]  tim_en;
  logic        tim_pend;
  logic        take_tim;
  logic        take_trap;
  logic        mask_q;
  logic [15:0] vec_d;
  assign tim_en    = ctl_q[rai_pkg::CTL_TIMER_LSB +: 3];
  assign tim_pend  = |(TIMER_FLAGS_IN & tim_en);
  // requests are only looked at on instruction boundaries
  assign take_irq  = BOUNDARY_IN & ~rst_q & ~mask_q & irq_req_q;
  assign take_tim  = BOUNDARY_IN & ~rst_q & ~mask_q & ~irq_req_q & tim_pend;
  assign take_trap = BOUNDARY_IN & ~rst_q & SOFTWARE_TRAP_IN & ~take_irq & ~take_tim;

  always_comb begin
    vec_d = VECTOR_OUT;
    if (rst_q) begin
      vec_d = rai_pkg::VEC_RESET;
    end else if (take_irq) begin
      vec_d = rai_pkg::VEC_IRQ;
    end else if (take_tim) begin
      vec_d = rai_pkg::VEC_TIMER;
    end else if (take_trap) begin
      vec_d = rai_pkg::VEC_TRAP;
    end
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      mask_q <= 1'b1;
    end else if (rst_q || take_irq || take_tim || take_trap) begin
      mask_q <= 1'b1;
    end else if (RETURN_TRAP_IN) begin
      mask_q <= STACKED_MASK_IN;
    end else if (MASK_LOAD_IN) begin
      mask_q <= MASK_VAL_IN;
    end
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      TAKE_OUT   <= 1'b0;
      STACK_OUT  <= 1'b0;
      VECTOR_OUT <= rai_pkg::VEC_RESET;
    end else begin
      TAKE_OUT   <= take_irq | take_tim | take_trap;
      STACK_OUT  <= take_irq | take_tim | take_trap;
      VECTOR_OUT <= vec_d;
    end
  end

  assign RST_OUT      = rst_q;
  assign MASK_OUT     = mask_q;
  assign MODE_SEL_OUT = mode_q;

  // ---------------------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------------------
  logic [31:0] rd_d;
  logic        err_d;
  always_comb begin
    rd_d  = 32'h00000000;
    err_d = 1'b0;
    unique case (PADDR_IN)
      rai_pkg::WATCHDOG_CLEAR_OFS: rd_d = {24'h000000, rai_pkg::UNUSED_VEC_LO};
      rai_pkg::CONTROL_OFS:        rd_d = {26'h0, ctl_q};
      rai_pkg::STATUS_OFS:         rd_d = {22'h0, TIMER_FLAGS_IN, capt_latch_q, mask_q,
                                           irq_req_q, edge_q, wd_fired_q, por_q, rst_q};
      default:                     err_d = 1'b1;
    endcase
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      PREADY_OUT  <= 1'b0;
      PRDATA_OUT  <= 32'h00000000;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= PSEL_IN & ~PENABLE_IN;
      if (PSEL_IN && !PENABLE_IN) begin
        PRDATA_OUT  <= PWRITE_IN ? 32'h00000000 : rd_d;
        PSLVERR_OUT <= err_d;
      end else begin
        PSLVERR_OUT <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!NRST_IN);

  AST_RST_MERGE: assert property (rst_d |=> rst_q)
    else $error("internal reset missed a source");
  AST_EXT_HOLD: assert property (!ext_rst_n |=> RST_OUT)
    else $error("reset released while pin low");
  AST_POR_LEN: assert property ($fell(por_q) |-> por_cnt_q == 12'hfe0)
    else $error("power-on delay length wrong");
  AST_POR_OTHER: assert property ($fell(por_q) && !ext_rst_n |=> RST_OUT)
    else $error("reset ended with other source active");
  AST_WD_FIRE: assert property (wd_active && !rst_q && wd_cnt_q == WDOG_LIMIT
                                |=> wd_pulse_q == 3'h4 ##1 RST_OUT)
    else $error("watchdog overflow gave no reset");
  AST_WD_CLEAR: assert property (wd_clear |=> wd_cnt_q == 18'h00000)
    else $error("watchdog clear write ignored");
  AST_WD_VPP: assert property (vpp_high |=> wd_pulse_q == 3'h0 || $past(wd_pulse_q) != 3'h0)
    else $error("watchdog fired under programming voltage");
  AST_WD_OTHER: assert property (wd_pulse_q == 3'h1 && !ext_rst_n |=> ##1 RST_OUT)
    else $error("reset dropped after watchdog with pin low");
  AST_MASK_GATE: assert property (TAKE_OUT && VECTOR_OUT != rai_pkg::VEC_TRAP
                                  |-> !$past(mask_q))
    else $error("hardware request taken while masked");
  AST_TAKE_MASK: assert property (take_irq || take_tim || take_trap
                                  |=> TAKE_OUT && MASK_OUT)
    else $error("take without mask set");
  AST_PRIO: assert property (take_irq |=> VECTOR_OUT == rai_pkg::VEC_IRQ)
    else $error("external request lost priority");
  AST_EDGE_CLR: assert property (take_irq ##1 (!(eff_n_q && !eff_n))[*8] ##1 !(eff_n_q && !eff_n)
                                 |=> !edge_q)
    else $error("edge latch not cleared after nine cycles");
  AST_LEVEL_OFF: assert property (!ctl_q[rai_pkg::CTL_LEVEL] && !edge_q |=> !irq_req_q)
    else $error("level seen with level sense off");
  AST_RST_VEC: assert property (rst_q |=> VECTOR_OUT == rai_pkg::VEC_RESET && MASK_OUT)
    else $error("reset vector or mask wrong");

  COV_WD_RESET: cover property (wd_pulse_q == 3'h4);
  COV_IRQ_TAKE: cover property (take_irq ##[1:20] edge_clear);
  COV_TIMER_TAKE: cover property (take_tim);
  COV_TRAP_AFTER_HW: cover property (take_irq ##[1:50] take_trap);
endmodule : rai_top

// *** testbench/rai_cpu_model.sv ***
// partner: cpu core issuing boundaries and mask updates, logging fetched vectors
`timescale 1ns/1ns
module rai_cpu_model (
  input  wire logic        clk_in,
  input  wire logic        take_in,
  input  wire logic [15:0] vector_in,
  output logic             boundary_out,
  output logic             trap_out,
  output logic             ret_out,
  output logic             smask_out,
  output logic             mload_out,
  output logic             mval_out
);
  logic [15:0] got_q[$];
  initial begin
    {boundary_out, trap_out, ret_out, smask_out, mload_out, mval_out} = 6'h00;
  end
  // vector only valid on the take pulse
  always @(posedge clk_in) if (take_in) got_q.push_back(vector_in);
  // boundary only between instructions, so requests wait here
  task automatic step(input logic trap);
    @(posedge clk_in);
    boundary_out <= 1'b1;
    trap_out     <= trap;
    @(posedge clk_in);
    boundary_out <= 1'b0;
    trap_out     <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask : step
  task automatic load_mask(input logic v);
    @(posedge clk_in);
    mload_out <= 1'b1;
    mval_out  <= v;
    @(posedge clk_in);
    mload_out <= 1'b0;
  endtask : load_mask
  task automatic ret(input logic m);
    @(posedge clk_in);
    ret_out   <= 1'b1;
    smask_out <= m;
    @(posedge clk_in);
    ret_out   <= 1'b0;
  endtask : ret
endmodule : rai_cpu_model

// *** testbench/rai_top_tb.sv ***
// testbench: reset merge, watchdog, registers and interrupt arbitration
`timescale 1ns/1ns
module rai_top_tb;
  logic        clk = 1'b0;
  logic        nrst, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr, vec;
  logic [31:0] pwdata, prdata;
  logic        rst_n_pin, irq_n, vpp, capt, bnd, trap, ret, smask, mload, mval;
  logic        rst, take, stack, mask, msel;
  logic [7:0]  porta;
  logic [2:0]  tflags;
  logic [15:0] exp_q[$];
  int          n_fail = 0;
  int          total_checks = 0;
  int          rst_cyc = 0;
  int          n, b;
  logic        cv;
  localparam int WD_LIM = 64;
  always #5 clk = ~clk;
  always @(posedge clk) rst_cyc <= rst_cyc + int'(rst);
  always @(posedge clk) begin
    if (nrst === 1'b1 && stack !== take) begin
      n_fail++;
      $display("unexpected at %0t: stack pulse differs from take pulse", $time);
    end
  end
  rai_top #(.WDOG_LIMIT(18'(WD_LIM))) uut (
    .MCLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .RESET_N_IN(rst_n_pin), .IRQ_N_IN(irq_n), .VPP_HIGH_IN(vpp),
    .CAPTURE_MODE_PIN_IN(capt), .PORTA_N_IN(porta), .TIMER_FLAGS_IN(tflags),
    .BOUNDARY_IN(bnd), .SOFTWARE_TRAP_IN(trap), .RETURN_TRAP_IN(ret), .STACKED_MASK_IN(smask),
    .MASK_LOAD_IN(mload), .MASK_VAL_IN(mval), .RST_OUT(rst), .TAKE_OUT(take),
    .STACK_OUT(stack), .VECTOR_OUT(vec), .MASK_OUT(mask), .MODE_SEL_OUT(msel));
  rai_cpu_model cpu (.clk_in(clk), .take_in(take), .vector_in(vec), .boundary_out(bnd),
    .trap_out(trap), .ret_out(ret), .smask_out(smask), .mload_out(mload), .mval_out(mval));
  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // two-phase transfer, waits on pready; only the guard ends a hung wait
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    chk(pslverr, ee, "slverr");
    if (!wr) chk(prdata, ed, "rdata");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmp_takes;
    chk(cpu.got_q.size(), exp_q.size(), "take count");
    while (exp_q.size() > 0 && cpu.got_q.size() > 0)
      chk(cpu.got_q.pop_front(), exp_q.pop_front(), "vector");
    exp_q.delete();
    cpu.got_q.delete();
  endtask : cmp_takes
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // guard sized well above the ~5000 cycle sequence
  initial begin
    #400000;
    n_fail++;
    test_done();
  end
  // --------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------
  initial begin
    {nrst, psel, penable, pwrite, vpp, capt} = 6'h00;
    {paddr, pwdata, tflags} = 51'h0;
    {rst_n_pin, irq_n, porta} = 10'h3ff;
    void'($urandom(32'h68aeac1f));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    chk(rst, 1'b1, "reset");
    chk(vec, rai_pkg::VEC_RESET, "rst vec");
    chk(mask, 1'b1, "rst mask");
    n = 0;
    while (rst !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk(n >= 4062 && n <= 4072, 1'b1, "por length");
    apb(1'b0, rai_pkg::CONTROL_OFS, 32'h0, 32'h0, 1'b0);
    apb(1'b0, rai_pkg::WATCHDOG_CLEAR_OFS, 32'h0, {24'h0, rai_pkg::UNUSED_VEC_LO}, 1'b0);
    apb(1'b1, 16'h1f00, $urandom, 32'h0, 1'b1);
    apb(1'b0, 16'h1f00, 32'h0, 32'h0, 1'b1);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, rai_pkg::CONTROL_OFS, s ? 32'h4 : 32'h0, 32'h0, 1'b0);
      b = $urandom_range(7, 0);
      if (s) porta[b] <= 1'b0;
      else irq_n <= 1'b0;
      repeat (8) @(posedge clk);
      porta <= 8'hff;
      irq_n <= 1'b1;
      cpu.load_mask(1'b0);
      cpu.step(1'b0);
      exp_q.push_back(rai_pkg::VEC_IRQ);
      chk(mask, 1'b1, "mask on take");
      repeat (12) @(posedge clk);
      cpu.load_mask(1'b0);
      cpu.step(1'b0);
      cmp_takes();
    end
    apb(1'b1, rai_pkg::CONTROL_OFS, 32'h38, 32'h0, 1'b0);
    for (int f = 0; f < 3; f++) begin
      tflags <= 3'(1 << f);
      cpu.load_mask(1'b1);
      cpu.step(1'b0);
      cpu.load_mask(1'b0);
      cpu.step(1'b0);
      exp_q.push_back(rai_pkg::VEC_TIMER);
    end
    cmp_takes();
    apb(1'b1, rai_pkg::CONTROL_OFS, 32'h0, 32'h0, 1'b0);
    tflags <= 3'($urandom_range(7, 1));
    cpu.load_mask(1'b0);
    cpu.step(1'b0);
    cmp_takes();
    apb(1'b1, rai_pkg::CONTROL_OFS, 32'h38, 32'h0, 1'b0);
    irq_n <= 1'b0;
    repeat (8) @(posedge clk);
    irq_n <= 1'b1;
    cpu.step(1'b1);
    cpu.step(1'b1);
    repeat (5) @(posedge clk);
    cpu.ret(1'b0);
    @(posedge clk);
    chk(mask, 1'b0, "mask restored");
    cpu.step(1'b0);
    exp_q = '{rai_pkg::VEC_IRQ, rai_pkg::VEC_TRAP, rai_pkg::VEC_TIMER};
    cmp_takes();
    tflags <= 3'h0;
    cv = 1'($urandom);
    capt <= cv;
    apb(1'b1, rai_pkg::CONTROL_OFS, 32'h1, 32'h0, 1'b0);
    n = rst_cyc;
    for (int i = 0; i < 8; i++) begin
      repeat (30) @(posedge clk);
      apb(1'b1, rai_pkg::WATCHDOG_CLEAR_OFS, $urandom & 32'hfffffffe, 32'h0, 1'b0);
    end
    chk(rst_cyc - n, 0, "cleared watchdog bit");
    // pin falls late enough to let the watchdog fire, early enough to outlast its pulse
    n = 0;
    while (rst !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
      if (n == WD_LIM - 2) rst_n_pin <= 1'b0;
    end
    chk(n, WD_LIM + 3, "watchdog timeout");
    b = rst_cyc;
    apb(1'b1, rai_pkg::CONTROL_OFS, 32'h0, 32'h0, 1'b0);
    repeat (20) @(posedge clk);
    chk(rst, 1'b1, "held by pin");
    chk(rst_cyc - b, 23, "reset gap after watchdog pulse");
    rst_n_pin <= 1'b1;
    n = 0;
    while (rst !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk(n < 5000, 1'b1, "pin release");
    chk(vec, rai_pkg::VEC_RESET, "vec after reset");
    chk(mask, 1'b1, "mask after reset");
    chk(msel, cv, "mode after pin reset");
    capt <= ~cv;
    vpp <= 1'b1;
    apb(1'b1, rai_pkg::CONTROL_OFS, 32'h1, 32'h0, 1'b0);
    n = rst_cyc;
    repeat (200) @(posedge clk);
    chk(rst_cyc - n, 0, "suppressed watchdog");
    // watchdog alone: mode from the latched pin, not the live one
    vpp <= 1'b0;
    n = 0;
    while (rst !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(n < 200, 1'b1, "watchdog restored");
    while (rst !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    apb(1'b1, rai_pkg::CONTROL_OFS, 32'h0, 32'h0, 1'b0);
    chk(msel, cv, "mode after watchdog reset");
    test_done();
  end
endmodule : rai_top_tb
